// >>> common/fste_pkg.sv
// shared constants for the floppy sector transfer engine
package fste_pkg;
    typedef enum logic [2:0] {
        FSTE_CMD_READ, FSTE_CMD_READ_DEL, FSTE_CMD_READ_TRACK,
        FSTE_CMD_WRITE, FSTE_CMD_WRITE_DEL
    } fste_cmd_e;
    localparam logic [1:0] FSTE_IC_NORMAL = 2'h0;
    localparam logic [1:0] FSTE_IC_ABNORMAL = 2'h1;
    localparam logic [15:0] FSTE_BASE_SIZE = 16'h0080;
    localparam logic [7:0] FSTE_SHORT_MAX = 8'h80;
    localparam logic [7:0] FSTE_FIRST_SECTOR = 8'h01;
    localparam logic [7:0] FSTE_ZERO_BYTE = 8'h00;
    localparam logic [1:0] FSTE_INDEX_LIMIT = 2'h2;
    localparam logic [2:0] FSTE_SIZE_CODE_MAX = 3'h7;
    localparam logic [15:0] FSTE_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] FSTE_CRC_POLY = 16'h1021;
    // head settling and unload intervals, in clock cycles
    localparam logic [15:0] FSTE_SETTLE_CYCLES = 16'h0100;
    localparam logic [15:0] FSTE_UNLOAD_CYCLES = 16'h0400;
endpackage

// >>> logic/fste_engine.sv
// execution-phase sequencer for floppy read and write transfer commands
`timescale 1ns/1ns
// What this block does
// - read loads head, settles, scans IDs, reads matched sector into FIFO.
// - after each sector, sector number increments and the next one streams.
// - terminal count or FIFO fault stops host data; sector finishes, CRC checked.
// - sector size is 128 shifted left by sector size code.
// - code zero with short length below 128 transfers only that many bytes.
// - both sides flag continues from side 0 through side 1 of cylinder; track read goes to the next cylinder instead.
// - head stays loaded until unload interval ends; new command skips settle.
// - two index pulses without sector gives abnormal code, sector missing.
// - read CRC error gives abnormal code, CRC fault, ID field flag, stop.
// - normal read: deleted mark sets mismatch; skip flag picks stop or skip.
// - deleted read swaps mark roles for mismatch, stop and skip.
// - track read starts at index, reads all fields, flags errors at end.
// - track read without ID mark by second index: abnormal, mark missing.
// - result ID: R+1 below last; at last R=1, cylinder or head advances.
// - write matches ID then writes FIFO data into the data field.
// - write appends CRC, increments sector number, continues.
// - terminal count or FIFO fault during write pads the field with zeros.
// - write checks ID CRC; error gives abnormal code, CRC fault, stop.
// - deleted write emits a deleted data mark before each field.
// - implied seek runs first, shows busy; failure reported with cylinder.
module fste_engine
    import fste_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic START,
    input wire fste_pkg::fste_cmd_e COMMAND,
    input wire logic BOTH_SIDES_FLAG,
    input wire logic SKIP_FLAG,
    input wire logic IMPLIED_SEEK_ENABLE,
    input wire logic [7:0] CYLINDER,
    input wire logic [7:0] HEAD,
    input wire logic [7:0] SECTOR,
    input wire logic [2:0] SECTOR_SIZE_CODE,
    input wire logic [7:0] LAST_SECTOR_NUMBER,
    input wire logic [7:0] SHORT_LENGTH,
    input wire logic SEEK_DONE,
    input wire logic SEEK_FAIL,
    input wire logic INDEX_PULSE,
    input wire logic ID_VALID,
    input wire logic [7:0] ID_CYLINDER,
    input wire logic [7:0] ID_HEAD,
    input wire logic [7:0] ID_SECTOR,
    input wire logic ID_CRC_OK,
    input wire logic MARK_VALID,
    input wire logic MARK_DELETED,
    input wire logic DISK_BYTE_VALID,
    input wire logic [7:0] DISK_BYTE,
    input wire logic DATA_CRC_OK,
    input wire logic TERMINAL_COUNT_INPUT,
    input wire logic FIFO_FAULT,
    input wire logic [7:0] HOST_BYTE,
    input wire logic DISK_BYTE_TAKEN,
    output logic HEAD_LOAD,
    output logic SEEK_REQUEST,
    output logic DRIVE_BUSY,
    output logic HOST_BYTE_VALID,
    output logic [7:0] HOST_BYTE_OUT,
    output logic HOST_BYTE_TAKE,
    output logic WRITE_MARK,
    output logic WRITE_MARK_DELETED,
    output logic WRITE_BYTE_VALID,
    output logic [7:0] WRITE_BYTE,
    output logic WRITE_CRC,
    output logic DONE,
    output logic [7:0] STATUS_ZERO,
    output logic [7:0] STATUS_ONE,
    output logic [7:0] STATUS_TWO,
    output logic [7:0] RESULT_CYLINDER,
    output logic [7:0] RESULT_HEAD,
    output logic [7:0] RESULT_SECTOR
);
    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [3:0] {
        FSTE_IDLE, FSTE_SEEK, FSTE_SETTLE, FSTE_SEARCH, FSTE_MARK,
        FSTE_RDATA, FSTE_WMARK, FSTE_WDATA, FSTE_WCRC, FSTE_NEXT, FSTE_END
    } fste_state_e;

    fste_state_e state_reg, state_next;
    fste_cmd_e cmd_reg, cmd_next;
    logic [7:0] cyl_reg, cyl_next, head_reg, head_next, sec_reg, sec_next;
    logic [15:0] count_reg, count_next, timer_reg, timer_next;
    logic [1:0] index_reg, index_next;
    logic stop_reg, stop_next, skip_reg, skip_next, halt_reg, halt_next;
    logic seen_id_reg, seen_id_next, loaded_reg, loaded_next;
    logic [15:0] unload_reg, unload_next;
    logic [7:0] st0_reg, st0_next, st1_reg, st1_next, st2_reg, st2_next;
    logic host_v_reg, host_v_next, wr_v_reg, wr_v_next;
    logic [7:0] host_b_reg, host_b_next, wr_b_reg, wr_b_next;
    logic done_reg, done_next, mark_reg, mark_next, crc_reg, crc_next;
    logic [15:0] size_bytes, xfer_bytes;
    logic is_read, is_write, is_track, id_match, mark_wrong, last_sec;

    // decoded command class and sector geometry
    always_comb begin
        is_read = (cmd_reg == FSTE_CMD_READ) || (cmd_reg == FSTE_CMD_READ_DEL);
        is_track = (cmd_reg == FSTE_CMD_READ_TRACK);
        is_write = (cmd_reg == FSTE_CMD_WRITE) || (cmd_reg == FSTE_CMD_WRITE_DEL);
        size_bytes = FSTE_BASE_SIZE << SECTOR_SIZE_CODE;
        // short length only counts for the smallest size; else ignored
        xfer_bytes = ((SECTOR_SIZE_CODE == 3'h0) && (SHORT_LENGTH < FSTE_SHORT_MAX))
            ? {8'h00, SHORT_LENGTH} : size_bytes;
        id_match = (ID_CYLINDER == cyl_reg) && (ID_HEAD == head_reg) && (ID_SECTOR == sec_reg);
        // deleted read swaps which mark counts as wrong
        mark_wrong = (cmd_reg == FSTE_CMD_READ_DEL) ? !MARK_DELETED : MARK_DELETED;
        last_sec = (sec_reg == LAST_SECTOR_NUMBER);
    end

    // ==========================================================
    // sequencer next state
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        cyl_next = cyl_reg;
        head_next = head_reg;
        sec_next = sec_reg;
        count_next = count_reg;
        timer_next = timer_reg;
        index_next = index_reg;
        stop_next = stop_reg;
        skip_next = skip_reg;
        halt_next = halt_reg;
        seen_id_next = seen_id_reg;
        loaded_next = loaded_reg;
        unload_next = unload_reg;
        st0_next = st0_reg;
        st1_next = st1_reg;
        st2_next = st2_reg;
        host_v_next = 1'b0;
        host_b_next = host_b_reg;
        wr_v_next = 1'b0;
        wr_b_next = wr_b_reg;
        done_next = 1'b0;
        mark_next = 1'b0;
        crc_next = 1'b0;
        // head unload countdown runs only while idle
        if (state_reg == FSTE_IDLE && loaded_reg) begin
            if (unload_reg == 16'h0000) begin
                loaded_next = 1'b0;
            end else begin
                unload_next = unload_reg - 16'h0001;
            end
        end
        case (state_reg)
            FSTE_IDLE: begin
                // START comes only after the command bytes are
                if (START) begin
                    cmd_next = COMMAND;
                    cyl_next = CYLINDER;
                    head_next = HEAD;
                    sec_next = SECTOR;
                    st0_next = 8'h00;
                    st1_next = 8'h00;
                    st2_next = 8'h00;
                    index_next = 2'h0;
                    seen_id_next = 1'b0;
                    // a head still loaded skips settling; the load flag itself rises
                    // on the first settle cycle, so it cannot gate the wait
                    timer_next = loaded_reg ? 16'h0000 : FSTE_SETTLE_CYCLES;
                    state_next = IMPLIED_SEEK_ENABLE ? FSTE_SEEK : FSTE_SETTLE;
                end
            end
            FSTE_SEEK: begin
                if (SEEK_FAIL) begin
                    st0_next[7:6] = FSTE_IC_ABNORMAL;
                    state_next = FSTE_END;
                end else if (SEEK_DONE) begin
                    state_next = FSTE_SETTLE;
                end
            end
            FSTE_SETTLE: begin
                // head loads here; the timer runs out before the ID scan
                loaded_next = 1'b1;
                if (timer_reg == 16'h0000) begin
                    index_next = 2'h0;
                    // track read begins only at the index pulse
                    state_next = (is_track && !INDEX_PULSE) ? FSTE_SETTLE : FSTE_SEARCH;
                end else begin
                    timer_next = timer_reg - 16'h0001;
                end
            end
            FSTE_SEARCH: begin
                if (INDEX_PULSE) begin
                    index_next = index_reg + 2'h1;
                end
                if (INDEX_PULSE && index_reg == FSTE_INDEX_LIMIT - 2'h1) begin
                    st0_next[7:6] = FSTE_IC_ABNORMAL;
                    if (is_track && !seen_id_reg) begin
                        st1_next[0] = 1'b1;
                    end else begin
                        st1_next[2] = 1'b1;
                    end
                    state_next = FSTE_END;
                end else if (ID_VALID) begin
                    seen_id_next = 1'b1;
                    if (!ID_CRC_OK && !is_track) begin
                        // ID CRC error ends read and write alike
                        st0_next[7:6] = FSTE_IC_ABNORMAL;
                        st1_next[5] = 1'b1;
                        st2_next[5] = 1'b1;
                        state_next = FSTE_END;
                    end else if (is_track) begin
                        if (!ID_CRC_OK) begin
                            st1_next[5] = 1'b1; // flagged, read goes on
                            st2_next[5] = 1'b1;
                        end
                        if (!id_match) begin
                            st1_next[2] = 1'b1;
                        end
                        count_next = 16'h0000;
                        state_next = FSTE_MARK;
                    end else if (id_match) begin
                        count_next = 16'h0000;
                        stop_next = 1'b0;
                        state_next = is_write ? FSTE_WMARK : FSTE_MARK;
                    end
                end
            end
            FSTE_MARK: begin
                if (MARK_VALID) begin
                    stop_next = 1'b0;
                    skip_next = 1'b0;
                    halt_next = 1'b0;
                    if (is_read && mark_wrong) begin
                        st2_next[6] = 1'b1;
                        if (SKIP_FLAG) begin
                            skip_next = 1'b1;
                        end else begin
                            halt_next = 1'b1;
                        end
                    end
                    state_next = FSTE_RDATA;
                end
            end
            FSTE_RDATA: begin
                if (TERMINAL_COUNT_INPUT || FIFO_FAULT) begin
                    stop_next = 1'b1;
                end
                if (DISK_BYTE_VALID) begin
                    count_next = count_reg + 16'h0001;
                    // skipped sectors and bytes past short length stay on the disk side
                    if (!stop_reg && !skip_reg && !TERMINAL_COUNT_INPUT && !FIFO_FAULT
                        && count_reg < xfer_bytes) begin
                        host_v_next = 1'b1;
                        host_b_next = DISK_BYTE;
                    end
                    if (count_reg == size_bytes - 16'h0001) begin
                        // full sector read before CRC verdict
                        if (!DATA_CRC_OK) begin
                            st1_next[5] = 1'b1;
                            if (!is_track) begin
                                st0_next[7:6] = FSTE_IC_ABNORMAL;
                            end
                        end
                        if (!DATA_CRC_OK && !is_track) begin
                            state_next = FSTE_END;
                        end else if (halt_reg) begin
                            state_next = FSTE_END; // no increment
                        end else if (stop_reg || TERMINAL_COUNT_INPUT || FIFO_FAULT) begin
                            state_next = FSTE_NEXT;
                            stop_next = 1'b1;
                        end else begin
                            state_next = FSTE_NEXT;
                        end
                    end
                end
            end
            FSTE_WMARK: begin
                mark_next = 1'b1;
                state_next = FSTE_WDATA;
            end
            FSTE_WDATA: begin
                if (TERMINAL_COUNT_INPUT || FIFO_FAULT) begin
                    stop_next = 1'b1;
                end
                if (DISK_BYTE_TAKEN || !wr_v_reg) begin
                    if (count_reg == size_bytes) begin
                        state_next = FSTE_WCRC;
                    end else begin
                        wr_v_next = 1'b1;
                        count_next = count_reg + 16'h0001;
                        // zero fill after short length or a stop
                        wr_b_next = (stop_reg || TERMINAL_COUNT_INPUT || FIFO_FAULT
                            || count_reg >= xfer_bytes) ? FSTE_ZERO_BYTE : HOST_BYTE;
                    end
                end else begin
                    wr_v_next = 1'b1;
                end
            end
            FSTE_WCRC: begin
                crc_next = 1'b1;
                state_next = FSTE_NEXT;
            end
            FSTE_NEXT: begin
                // result ID follows the last sector handled
                if (last_sec) begin
                    sec_next = FSTE_FIRST_SECTOR;
                    if (BOTH_SIDES_FLAG && !is_track) begin
                        head_next = {head_reg[7:1], ~head_reg[0]};
                        if (head_reg[0]) begin
                            cyl_next = cyl_reg + 8'h01;
                        end
                    end else begin
                        cyl_next = cyl_reg + 8'h01;
                    end
                end else begin
                    sec_next = sec_reg + 8'h01;
                end
                index_next = 2'h0;
                // side 0 continues under both sides flag, to side 1 (track read: to the next cylinder)
                if (stop_reg || (last_sec && !(BOTH_SIDES_FLAG && !head_reg[0]))) begin
                    state_next = FSTE_END;
                end else begin
                    state_next = FSTE_SEARCH;
                end
            end
            FSTE_END: begin
                done_next = 1'b1;
                unload_next = FSTE_UNLOAD_CYCLES;
                state_next = FSTE_IDLE;
            end
            default: begin
                state_next = FSTE_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= FSTE_IDLE;
            cmd_reg <= FSTE_CMD_READ;
            cyl_reg <= 8'h00;
            head_reg <= 8'h00;
            sec_reg <= 8'h00;
            count_reg <= 16'h0000;
            timer_reg <= 16'h0000;
            index_reg <= 2'h0;
            stop_reg <= 1'b0;
            skip_reg <= 1'b0;
            halt_reg <= 1'b0;
            seen_id_reg <= 1'b0;
            loaded_reg <= 1'b0;
            unload_reg <= 16'h0000;
            st0_reg <= 8'h00;
            st1_reg <= 8'h00;
            st2_reg <= 8'h00;
            host_v_reg <= 1'b0;
            host_b_reg <= 8'h00;
            wr_v_reg <= 1'b0;
            wr_b_reg <= 8'h00;
            done_reg <= 1'b0;
            mark_reg <= 1'b0;
            crc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            cyl_reg <= cyl_next;
            head_reg <= head_next;
            sec_reg <= sec_next;
            count_reg <= count_next;
            timer_reg <= timer_next;
            index_reg <= index_next;
            stop_reg <= stop_next;
            skip_reg <= skip_next;
            halt_reg <= halt_next;
            seen_id_reg <= seen_id_next;
            loaded_reg <= loaded_next;
            unload_reg <= unload_next;
            st0_reg <= st0_next;
            st1_reg <= st1_next;
            st2_reg <= st2_next;
            host_v_reg <= host_v_next;
            host_b_reg <= host_b_next;
            wr_v_reg <= wr_v_next;
            wr_b_reg <= wr_b_next;
            done_reg <= done_next;
            mark_reg <= mark_next;
            crc_reg <= crc_next;
        end
    end

    // outputs; handshake take is combinational, data from flops
    assign HEAD_LOAD = loaded_reg;
    assign SEEK_REQUEST = (state_reg == FSTE_SEEK);
    assign DRIVE_BUSY = (state_reg == FSTE_SEEK);
    assign HOST_BYTE_VALID = host_v_reg;
    assign HOST_BYTE_OUT = host_b_reg;
    assign HOST_BYTE_TAKE = wr_v_next && (state_reg == FSTE_WDATA) && !(stop_next)
        && (count_reg < xfer_bytes) && (DISK_BYTE_TAKEN || !wr_v_reg);
    assign WRITE_MARK = mark_reg;
    assign WRITE_MARK_DELETED = mark_reg && (cmd_reg == FSTE_CMD_WRITE_DEL);
    assign WRITE_BYTE_VALID = wr_v_reg;
    assign WRITE_BYTE = wr_b_reg;
    assign WRITE_CRC = crc_reg;
    assign DONE = done_reg;
    assign STATUS_ZERO = st0_reg;
    assign STATUS_ONE = st1_reg;
    assign STATUS_TWO = st2_reg;
    assign RESULT_CYLINDER = cyl_reg;
    assign RESULT_HEAD = head_reg;
    assign RESULT_SECTOR = sec_reg;

    // ==========================================================
    // assertions
    // ==========================================================
    seek_busy_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_SEEK && SEEK_FAIL) |=> !DRIVE_BUSY
        && st0_reg[7:6] == FSTE_IC_ABNORMAL) else $error("seek failure not reported");
    index_end_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_SEARCH && INDEX_PULSE && index_reg == 2'h1)
        |=> st0_reg[7:6] == FSTE_IC_ABNORMAL ##1 done_reg) else $error("no end on 2nd index");
    crc_stop_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_SEARCH && ID_VALID && !ID_CRC_OK && !is_track
        && !(INDEX_PULSE && index_reg == 2'h1)) |=> st1_reg[5] && st2_reg[5])
        else $error("ID crc not flagged");
    del_mark_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_WMARK) |=> WRITE_MARK
        && (WRITE_MARK_DELETED == (cmd_reg == FSTE_CMD_WRITE_DEL)))
        else $error("bad deleted mark");
    zero_fill_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_WDATA && stop_reg && wr_v_next && (DISK_BYTE_TAKEN || !wr_v_reg))
        |=> WRITE_BYTE == FSTE_ZERO_BYTE)
        else $error("no zero fill after stop");
    stop_host_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_RDATA && stop_reg) |=> !HOST_BYTE_VALID)
        else $error("host data after stop");
    crc_after_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_WCRC) |=> WRITE_CRC) else $error("crc not appended");
    wrap_sec_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == FSTE_NEXT && last_sec) |=> RESULT_SECTOR == FSTE_FIRST_SECTOR)
        else $error("sector did not wrap");
    read_cov: cover property (@(posedge CLK) state_reg == FSTE_RDATA ##[1:1000] done_reg);
    write_cov: cover property (@(posedge CLK) WRITE_MARK ##[1:1000] WRITE_CRC);
    miss_cov: cover property (@(posedge CLK) st1_reg[2] && done_reg);
endmodule

// >>> verification/fste_media_model.sv
// media side model: a spinning four-sector track, a write sink and a seek responder
`timescale 1ns/1ns
module fste_media_model (
    input wire logic CLK,
    input wire logic SEEK_REQUEST,
    input wire logic WRITE_BYTE_VALID,
    input wire logic [7:0] RESULT_HEAD,
    output logic SEEK_DONE,
    output logic DISK_BYTE_TAKEN,
    output logic INDEX_PULSE,
    output logic ID_VALID,
    output logic [7:0] ID_CYLINDER,
    output logic [7:0] ID_HEAD,
    output logic [7:0] ID_SECTOR,
    output logic MARK_VALID,
    output logic MARK_DELETED,
    output logic DISK_BYTE_VALID,
    output logic [7:0] DISK_BYTE
);
    int pos = 0;
    int off;
    initial SEEK_DONE = 1'b0;
    initial DISK_BYTE_TAKEN = 1'b0;
    // the disk never stops turning, so the engine must find the index by itself
    always @(posedge CLK) begin
        pos <= (pos == 1199) ? 0 : pos + 1;
        SEEK_DONE <= SEEK_REQUEST && !SEEK_DONE;
        DISK_BYTE_TAKEN <= WRITE_BYTE_VALID && !DISK_BYTE_TAKEN;
    end
    // 300-cycle slots: id, mark at 4, bytes every other cycle; sector 3 carries a deleted mark
    always_comb begin
        off = pos % 300;
        INDEX_PULSE = (pos == 1199);
        ID_VALID = (off == 0);
        ID_CYLINDER = 8'h05;
        // the selected side answers with its own head number
        ID_HEAD = {7'h00, RESULT_HEAD[0]};
        ID_SECTOR = 8'(pos / 300 + 1);
        MARK_VALID = (off == 4);
        MARK_DELETED = (ID_SECTOR == 8'h03);
        DISK_BYTE_VALID = (off >= 10) && (off < 266) && (off % 2 == 0);
        // an idle data line shows the inverse, so a stale byte never passes for a fresh one
        DISK_BYTE = (ID_SECTOR << 4) ^ 8'((off - 10) / 2) ^ {8{!DISK_BYTE_VALID}};
    end
endmodule

// >>> verification/tb.sv
// self-checking bench for the floppy sector transfer engine
`timescale 1ns/1ns
module tb;
    import fste_pkg::*;
    logic CLK = 0, RESET = 1, START = 0, SKIP_FLAG = 0, IMPLIED_SEEK_ENABLE = 1, SEEK_FAIL = 0;
    logic BOTH_SIDES_FLAG = 0, TERMINAL_COUNT_INPUT = 0, FIFO_FAULT = 0, ID_CRC_OK = 1;
    logic DATA_CRC_OK = 1, del_exp = 0;
    fste_cmd_e COMMAND = FSTE_CMD_READ;
    logic [7:0] CYLINDER = 8'h05, HEAD = 8'h00, SECTOR = 8'h01, LAST_SECTOR_NUMBER = 8'h01;
    logic [7:0] SHORT_LENGTH = 8'hFF, HOST_BYTE = 8'h00;
    logic [2:0] SECTOR_SIZE_CODE = 3'h0;
    logic SEEK_DONE, INDEX_PULSE, ID_VALID, MARK_VALID, MARK_DELETED, DISK_BYTE_VALID;
    logic DISK_BYTE_TAKEN, HEAD_LOAD, SEEK_REQUEST, DRIVE_BUSY, HOST_BYTE_VALID, HOST_BYTE_TAKE;
    logic WRITE_MARK, WRITE_MARK_DELETED, WRITE_BYTE_VALID, WRITE_CRC, DONE;
    logic [7:0] ID_CYLINDER, ID_HEAD, ID_SECTOR, DISK_BYTE, HOST_BYTE_OUT, WRITE_BYTE;
    logic [7:0] STATUS_ZERO, STATUS_ONE, STATUS_TWO, RESULT_CYLINDER, RESULT_HEAD, RESULT_SECTOR;
    logic [7:0] exp_q[$], wr_q[$];
    int n_errors = 0, check_count = 0, n_taken = 0, n_crc = 0, tc_at = -1;
    fste_engine dut_u (.*);
    fste_media_model media_u (.*);
    initial forever #5 CLK = ~CLK;
    // one compare for every kind of result
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // media content: sector number in the high nibble, byte index mixed in
    task automatic expect_sector(input logic [7:0] s, input int n);
        for (int k = 0; k < n; k++) exp_q.push_back((s << 4) ^ 8'(k));
    endtask
    // status, result id; an FF byte in the expectation is left unchecked
    task automatic run(input fste_cmd_e c, input logic [7:0] s, last, input logic sk,
            input logic [39:0] e);
        int i;
        logic [39:0] g;
        n_taken = 0;
        n_crc = 0;
        wr_q.delete();
        @(negedge CLK);
        COMMAND = c;
        SECTOR = s;
        LAST_SECTOR_NUMBER = last;
        SKIP_FLAG = sk;
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
        for (i = 0; i < 6000 && DONE !== 1'b1; i++) @(negedge CLK);
        if (i == 6000) begin
            chk(40'h0, 40'h1, "no completion");
            tally_and_finish();
        end
        repeat (2) @(negedge CLK);
        g = {STATUS_ZERO & 8'hC0, STATUS_ONE & 8'h25, STATUS_TWO & 8'h60, RESULT_CYLINDER,
            RESULT_SECTOR};
        for (i = 0; i < 40; i += 8) if (e[i+:8] == 8'hFF) g[i+:8] = 8'hFF;
        chk(g, e, "result phase");
        chk(40'(exp_q.size()), 40'h0, "host bytes left over");
    endtask
    // watcher: each result that appears takes the oldest note
    always @(posedge CLK) begin
        if (HOST_BYTE_VALID === 1'b1) begin
            n_taken++;
            chk(40'(HOST_BYTE_OUT), exp_q.size() > 0 ? 40'(exp_q.pop_front()) : 40'h1FF, "host");
        end
        if (HOST_BYTE_TAKE === 1'b1) wr_q.push_back(HOST_BYTE);
        if (WRITE_BYTE_VALID === 1'b1 && DISK_BYTE_TAKEN === 1'b1) begin
            n_taken++;
            chk(40'(WRITE_BYTE), 40'(wr_q.size() > 0 ? wr_q.pop_front() : 8'h00), "disk");
        end
        if (WRITE_MARK === 1'b1) chk(40'(WRITE_MARK_DELETED), 40'(del_exp), "mark kind");
        if (WRITE_CRC === 1'b1) n_crc++;
    end
    // host data and terminal count change on the falling edge
    always @(negedge CLK) begin
        HOST_BYTE <= 8'($urandom);
        TERMINAL_COUNT_INPUT <= (n_taken == tc_at);
    end
    initial begin
        void'($urandom(44));
        repeat (5) @(negedge CLK);
        RESET = 1'b0;
        expect_sector(8'h01, 128);
        expect_sector(8'h02, 128);
        run(FSTE_CMD_READ, 8'h01, 8'h02, 1'b0, 40'h00_00_00_06_01);
        chk(40'(HEAD_LOAD), 40'h1, "head kept loaded");
        SEEK_FAIL = 1'b1;
        run(FSTE_CMD_READ, 8'h01, 8'h01, 1'b0, 40'h40_00_00_05_01);
        SEEK_FAIL = 1'b0;
        IMPLIED_SEEK_ENABLE = 1'b0;
        SHORT_LENGTH = 8'($urandom_range(127, 1));
        expect_sector(8'h02, int'(SHORT_LENGTH));
        run(FSTE_CMD_READ, 8'h02, 8'h02, 1'b0, 40'h00_00_00_06_01);
        SHORT_LENGTH = 8'hFF;
        tc_at = 10;
        expect_sector(8'h01, 10);
        run(FSTE_CMD_READ, 8'h01, 8'h02, 1'b0, 40'h00_00_00_05_02);
        tc_at = -1;
        BOTH_SIDES_FLAG = 1'b1;
        expect_sector(8'h04, 128);
        for (int s = 1; s < 4; s++) expect_sector(8'(s), 128);
        run(FSTE_CMD_READ, 8'h04, 8'h04, 1'b0, 40'hFF_00_40_05_03);
        chk(40'(RESULT_HEAD), 40'h1, "head after side change");
        BOTH_SIDES_FLAG = 1'b0;
        ID_CRC_OK = 1'b0;
        run(FSTE_CMD_READ, 8'h01, 8'h01, 1'b0, 40'h40_20_20_05_01);
        ID_CRC_OK = 1'b1;
        DATA_CRC_OK = 1'b0;
        expect_sector(8'h01, 128);
        run(FSTE_CMD_READ, 8'h01, 8'h02, 1'b0, 40'h40_20_00_05_01);
        DATA_CRC_OK = 1'b1;
        expect_sector(8'h03, 128);
        run(FSTE_CMD_READ, 8'h03, 8'h03, 1'b0, 40'hFF_00_40_05_03);
        expect_sector(8'h02, 128);
        run(FSTE_CMD_READ, 8'h02, 8'h03, 1'b1, 40'h00_00_40_06_01);
        expect_sector(8'h01, 128);
        run(FSTE_CMD_READ_DEL, 8'h01, 8'h01, 1'b0, 40'hFF_00_40_05_01);
        run(FSTE_CMD_READ, 8'h09, 8'h09, 1'b0, 40'h40_04_FF_FF_FF);
        for (int s = 1; s < 5; s++) expect_sector(8'(s), 128);
        run(FSTE_CMD_READ_TRACK, 8'h01, 8'h04, 1'b0, 40'h00_00_00_06_01);
        SHORT_LENGTH = 8'h14;
        run(FSTE_CMD_WRITE, 8'h01, 8'h01, 1'b0, 40'h00_00_00_06_01);
        chk(40'(n_taken * 256 + n_crc), 40'h8001, "write counts");
        SHORT_LENGTH = 8'hFF;
        del_exp = 1'b1;
        tc_at = 30;
        run(FSTE_CMD_WRITE_DEL, 8'h02, 8'h03, 1'b0, 40'hFF_00_00_05_03);
        chk(40'(n_taken), 40'h80, "bytes written after stop");
        tally_and_finish();
    end
endmodule
